// *** core/srts_pkg.sv ***
package srts_pkg;
    // Status bit positions
    localparam int SR_TX_READY = 0;
    localparam int SR_RX_READY = 1;
    localparam int SR_TX_EMPTY = 2;
    localparam int SR_PARITY = 3;
    localparam int SR_OVERRUN = 4;
    localparam int SR_WORD_ERR = 5;
    localparam int SR_FIRST_CHAR = 6;
    localparam int SR_UNDERRUN = 7;
    localparam logic [7:0] STATUS_RESET = 8'h05;
    localparam logic [7:0] RX_HOLD_RESET = 8'h00;
    localparam logic [7:0] DATA_OUT_RESET = 8'h00;
    // Pins idle: cs_n, reg_select, rd_n, wr_n high, data low
    localparam logic [11:0] PIN_IDLE = 12'hf00;
    localparam int PIN_SYNC_STAGES = 3;
    localparam int PIN_CS_N = 11;
    localparam int PIN_SEL = 10;
    localparam int PIN_RD_N = 9;
    localparam int PIN_WR_N = 8;
endpackage : srts_pkg

// *** core/srts_bus_if.sv ***
`timescale 1ns/100ps
interface srts_bus_if;
    logic rd_active;
    logic sel_status;
    logic rd_rx_done;
    logic wr_ctrl;
    logic wr_tx;
    logic [7:0] wdata;

    modport front (output rd_active, output sel_status, output rd_rx_done,
        output wr_ctrl, output wr_tx, output wdata);
    modport core (input rd_active, input sel_status, input rd_rx_done,
        input wr_ctrl, input wr_tx, input wdata);
endinterface : srts_bus_if

// *** core/srts_bus_front.sv ***
`timescale 1ns/100ps
module srts_bus_front #(
    parameter int STAGES = srts_pkg::PIN_SYNC_STAGES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic reg_select,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] data_in,
    srts_bus_if.front bus
);
    if (STAGES < 3) begin : g_bad_stages
        $error("srts_bus_front needs at least three sync stages");
    end

    logic [11:0] sync_r [STAGES];
    logic [11:0] sync_nxt [STAGES];
    logic [11:0] filt_r;
    logic [11:0] filt_nxt;
    logic [11:0] prev_r;
    logic [11:0] prev_nxt;

    // A bit is accepted only once the last two stages agree
    always_comb begin
        sync_nxt[0] = {cs_n, reg_select, rd_n, wr_n, data_in};
        for (int i = 1; i < STAGES; i++) begin
            sync_nxt[i] = sync_r[i-1];
        end
        filt_nxt = filt_r;
        for (int b = 0; b < 12; b++) begin
            if (sync_r[STAGES-2][b] == sync_r[STAGES-1][b]) begin
                filt_nxt[b] = sync_r[STAGES-1][b];
            end
        end
        prev_nxt = filt_r;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < STAGES; i++) begin
                sync_r[i] <= srts_pkg::PIN_IDLE;
            end
            filt_r <= srts_pkg::PIN_IDLE;
            prev_r <= srts_pkg::PIN_IDLE;
        end else begin
            sync_r <= sync_nxt;
            filt_r <= filt_nxt;
            prev_r <= prev_nxt;
        end
    end

    logic prev_sel;
    logic rd_end;
    logic wr_end;

    // Strobes act on their trailing edge, when the data bus is settled
    assign prev_sel = !prev_r[srts_pkg::PIN_CS_N];
    assign rd_end = !prev_r[srts_pkg::PIN_RD_N] && filt_r[srts_pkg::PIN_RD_N]
        && prev_r[srts_pkg::PIN_WR_N];
    assign wr_end = !prev_r[srts_pkg::PIN_WR_N] && filt_r[srts_pkg::PIN_WR_N]
        && prev_r[srts_pkg::PIN_RD_N];

    assign bus.rd_active = !filt_r[srts_pkg::PIN_CS_N] && !filt_r[srts_pkg::PIN_RD_N]
        && filt_r[srts_pkg::PIN_WR_N];
    assign bus.sel_status = filt_r[srts_pkg::PIN_SEL];
    assign bus.rd_rx_done = prev_sel && rd_end && !prev_r[srts_pkg::PIN_SEL];
    assign bus.wr_ctrl = prev_sel && wr_end && prev_r[srts_pkg::PIN_SEL];
    assign bus.wr_tx = prev_sel && wr_end && !prev_r[srts_pkg::PIN_SEL];
    assign bus.wdata = prev_r[7:0];
endmodule : srts_bus_front

// *** core/srts_status_port.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - Selected, reg_select high, read low, write high: status drives the data bus.
// - Selected, reg_select high, read high, write low: bus value is a control write.
// - Status order top to bottom: underrun, first char, word err, overrun, parity.
// - tx_empty_flag is high while transmitter idle, low while sending.
// - parity_error_flag sets when a received character fails parity.
// - word_error_flag sums sequence, overrun, parity and underrun errors.
// - first_char_ready sets once the first character of a word is held.
// - tx_ready updates within half a transmit clock of the bit centre.
// - tx_empty_flag updates within half a transmit clock of the last bit centre.
// - tx_ready sets when a character moves from holding to shift register.
// - Multi-character underrun when next character is late, except on the last.
// - reg_select low: read returns rx_holding_reg, write loads transmit holding.
module srts_status_port (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic reg_select,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic multi_char,
    input wire logic tx_shift_load,
    input wire logic tx_char_done,
    input wire logic tx_last_char,
    input wire logic tx_busy,
    input wire logic rx_char_done,
    input wire logic [7:0] rx_char,
    input wire logic rx_first,
    input wire logic rx_parity_bad,
    input wire logic rx_seq_bad,
    output logic [7:0] tx_hold_data,
    output logic tx_hold_full,
    output logic [7:0] control_data,
    output logic control_wr,
    output logic [7:0] status_flags
);
    srts_bus_if bus ();

    srts_bus_front #(
        .STAGES(srts_pkg::PIN_SYNC_STAGES)
    ) u_front (
        .clock(clock),
        .rst_n(rst_n),
        .cs_n(cs_n),
        .reg_select(reg_select),
        .rd_n(rd_n),
        .wr_n(wr_n),
        .data_in(data_in),
        .bus(bus)
    );

    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [7:0] rx_hold_r;
    logic [7:0] rx_hold_nxt;
    logic [7:0] tx_hold_r;
    logic [7:0] tx_hold_nxt;
    logic hold_full_r;
    logic hold_full_nxt;
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic ctrl_wr_r;
    logic ctrl_wr_nxt;
    logic [7:0] dout_r;
    logic [7:0] dout_nxt;

    logic set_overrun;
    logic set_parity;
    logic set_underrun;

    assign set_overrun = rx_char_done && status_r[srts_pkg::SR_RX_READY]
        && !bus.rd_rx_done;
    assign set_parity = rx_char_done && rx_parity_bad;
    // Late reload leaves the shifter with nothing; the word's last char is exempt
    assign set_underrun = tx_char_done && multi_char && !tx_last_char
        && !hold_full_r && !tx_shift_load;

    // Each flag takes one clock after its event, far inside half a bit clock
    always_comb begin
        status_nxt = status_r;
        rx_hold_nxt = rx_hold_r;
        tx_hold_nxt = tx_hold_r;
        hold_full_nxt = hold_full_r;
        ctrl_nxt = ctrl_r;
        ctrl_wr_nxt = 1'b0;
        // Error flags are sticky until the next control write
        if (bus.wr_ctrl) begin
            ctrl_nxt = bus.wdata;
            ctrl_wr_nxt = 1'b1;
            status_nxt[srts_pkg::SR_PARITY] = 1'b0;
            status_nxt[srts_pkg::SR_OVERRUN] = 1'b0;
            status_nxt[srts_pkg::SR_WORD_ERR] = 1'b0;
            status_nxt[srts_pkg::SR_UNDERRUN] = 1'b0;
        end
        if (bus.wr_tx) begin
            tx_hold_nxt = bus.wdata;
            hold_full_nxt = 1'b1;
            status_nxt[srts_pkg::SR_TX_READY] = 1'b0;
        end
        if (tx_shift_load) begin
            hold_full_nxt = bus.wr_tx;
            status_nxt[srts_pkg::SR_TX_READY] = 1'b1;
        end
        if (bus.rd_rx_done) begin
            status_nxt[srts_pkg::SR_RX_READY] = 1'b0;
            status_nxt[srts_pkg::SR_FIRST_CHAR] = 1'b0;
        end
        if (rx_char_done) begin
            rx_hold_nxt = rx_char;
            status_nxt[srts_pkg::SR_RX_READY] = 1'b1;
            if (rx_first) begin
                status_nxt[srts_pkg::SR_FIRST_CHAR] = 1'b1;
            end
        end
        if (set_overrun) begin
            status_nxt[srts_pkg::SR_OVERRUN] = 1'b1;
        end
        if (set_parity) begin
            status_nxt[srts_pkg::SR_PARITY] = 1'b1;
        end
        if (set_underrun) begin
            status_nxt[srts_pkg::SR_UNDERRUN] = 1'b1;
        end
        if (set_overrun || set_parity || set_underrun || rx_seq_bad) begin
            status_nxt[srts_pkg::SR_WORD_ERR] = 1'b1;
        end
        status_nxt[srts_pkg::SR_TX_EMPTY] = !tx_busy && !hold_full_nxt;
        dout_nxt = bus.sel_status ? status_r : rx_hold_r;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= srts_pkg::STATUS_RESET;
            rx_hold_r <= srts_pkg::RX_HOLD_RESET;
            tx_hold_r <= srts_pkg::RX_HOLD_RESET;
            hold_full_r <= 1'b0;
            ctrl_r <= srts_pkg::DATA_OUT_RESET;
            ctrl_wr_r <= 1'b0;
            dout_r <= srts_pkg::DATA_OUT_RESET;
        end else begin
            status_r <= status_nxt;
            rx_hold_r <= rx_hold_nxt;
            tx_hold_r <= tx_hold_nxt;
            hold_full_r <= hold_full_nxt;
            ctrl_r <= ctrl_nxt;
            ctrl_wr_r <= ctrl_wr_nxt;
            dout_r <= dout_nxt;
        end
    end

    assign data_out = dout_r;
    assign data_oe = bus.rd_active;
    assign tx_hold_data = tx_hold_r;
    assign tx_hold_full = hold_full_r;
    assign control_data = ctrl_r;
    assign control_wr = ctrl_wr_r;
    assign status_flags = status_r;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_rx_store;
        rx_char_done ##1 status_r[srts_pkg::SR_RX_READY];
    endsequence

    sequence s_error_event;
        set_overrun || set_parity || set_underrun || rx_seq_bad;
    endsequence

    // Two high select samples on the pin must leave the bus released
    a_oe_needs_cs: assert property ($past(cs_n, 3) && $past(cs_n, 4) |-> !data_oe)
        else $error("data bus driven without a selected read");
    a_status_readout: assert property (bus.sel_status |=> data_out == $past(status_r))
        else $error("status read returned wrong value");
    a_holding_readout: assert property (!bus.sel_status |=> data_out == $past(rx_hold_r))
        else $error("holding read returned wrong value");
    a_rx_ready_set: assert property (rx_char_done |-> s_rx_store)
        else $error("rx_ready not set after a character");
    a_rx_clear_read: assert property (bus.rd_rx_done && !rx_char_done
        |=> !status_flags[srts_pkg::SR_RX_READY] && !status_flags[srts_pkg::SR_FIRST_CHAR])
        else $error("holding read did not clear ready flags");
    a_first_char_set: assert property (rx_char_done && rx_first
        |=> status_flags[srts_pkg::SR_FIRST_CHAR] && rx_hold_r == $past(rx_char))
        else $error("first char flag or data wrong");
    a_overrun_set: assert property (set_overrun |=> status_flags[srts_pkg::SR_OVERRUN])
        else $error("overrun not flagged");
    a_parity_set: assert property (set_parity |=> status_flags[srts_pkg::SR_PARITY])
        else $error("parity error not flagged");
    a_word_error_sum: assert property (s_error_event |=> status_flags[srts_pkg::SR_WORD_ERR])
        else $error("word error not flagged");
    a_tx_ready_load: assert property (tx_shift_load |=> status_flags[srts_pkg::SR_TX_READY])
        else $error("tx_ready not set on shift load");
    a_tx_ready_clear: assert property (bus.wr_tx && !tx_shift_load
        |=> !status_flags[srts_pkg::SR_TX_READY] && tx_hold_full)
        else $error("holding write did not clear tx_ready");
    a_tx_empty_busy: assert property (tx_busy |=> !status_flags[srts_pkg::SR_TX_EMPTY])
        else $error("tx_empty high while sending");
    a_underrun_set: assert property (set_underrun
        |=> status_flags[srts_pkg::SR_UNDERRUN] && status_flags[srts_pkg::SR_WORD_ERR])
        else $error("underrun not flagged");
    a_ctrl_write: assert property (bus.wr_ctrl
        |=> control_wr && control_data == $past(bus.wdata))
        else $error("control write not taken");
    a_underrun_exempt: assert property (tx_char_done && tx_last_char
        && !status_flags[srts_pkg::SR_UNDERRUN] |=> !status_flags[srts_pkg::SR_UNDERRUN])
        else $error("underrun raised on the last character");
    a_tx_empty_idle: assert property (!tx_busy && !tx_hold_full && !bus.wr_tx
        |=> status_flags[srts_pkg::SR_TX_EMPTY])
        else $error("tx_empty low while idle");
    a_overrun_clean: assert property (rx_char_done && !status_flags[srts_pkg::SR_RX_READY]
        && !status_flags[srts_pkg::SR_OVERRUN] |=> !status_flags[srts_pkg::SR_OVERRUN])
        else $error("overrun raised on an empty holding register");
endmodule : srts_status_port

// *** dv/srts_host_model.sv ***
`timescale 1ns/100ps
module srts_host_model (
    input wire logic clock,
    output logic cs_n,
    output logic reg_select,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    initial begin
        {cs_n, reg_select, rd_n, wr_n, data_in} = srts_pkg::PIN_IDLE;
    end

    // Strobe held 8 clocks, well past the pin filter
    task automatic cyc(input logic [3:0] pins, input logic [7:0] d,
            output logic [7:0] q, output logic oe);
        @(negedge clock);
        {cs_n, reg_select, rd_n, wr_n} = pins;
        data_in = d;
        repeat (8) @(negedge clock);
        q = data_out;
        oe = data_oe;
        {rd_n, wr_n} = 2'b11;
        repeat (3) @(negedge clock);
        cs_n = 1'b1;
        // Released bus shows flipped data, never a stale byte
        data_in = ~d;
        repeat (12) @(negedge clock);
    endtask : cyc
endmodule : srts_host_model

// *** dv/srts_status_port_tb_top.sv ***
`timescale 1ns/100ps
module srts_status_port_tb_top;
    logic clock;
    logic rst_n;
    logic cs_n, reg_select, rd_n, wr_n, data_oe, tx_hold_full, control_wr, oe;
    logic multi_char, tx_last_char, tx_busy, rx_first, rx_parity_bad;
    logic tx_shift_load, tx_char_done, rx_char_done, rx_seq_bad;
    logic [7:0] data_in, data_out, rx_char, tx_hold_data, control_data, status_flags, q;
    int fails, checks_done, wr_pulses;

    srts_status_port dut (.clock(clock), .rst_n(rst_n), .cs_n(cs_n),
        .reg_select(reg_select), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .multi_char(multi_char),
        .tx_shift_load(tx_shift_load), .tx_char_done(tx_char_done),
        .tx_last_char(tx_last_char), .tx_busy(tx_busy), .rx_char_done(rx_char_done),
        .rx_char(rx_char), .rx_first(rx_first), .rx_parity_bad(rx_parity_bad),
        .rx_seq_bad(rx_seq_bad), .tx_hold_data(tx_hold_data),
        .tx_hold_full(tx_hold_full), .control_data(control_data),
        .control_wr(control_wr), .status_flags(status_flags));

    srts_host_model host (.clock(clock), .cs_n(cs_n), .reg_select(reg_select),
        .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Sampled mid-cycle, clear of the edge that launches the pulse
    always @(negedge clock) begin
        if (control_wr === 1'b1) wr_pulses <= wr_pulses + 1;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One-cycle event pulses from the serial side
    task automatic fire(input logic [3:0] m);
        @(negedge clock);
        {tx_shift_load, tx_char_done, rx_char_done, rx_seq_bad} = m;
        @(negedge clock);
        {tx_shift_load, tx_char_done, rx_char_done, rx_seq_bad} = 4'h0;
        @(negedge clock);
    endtask : fire

    task automatic rd(input logic sel);
        host.cyc({1'b0, sel, 2'b01}, 8'h00, q, oe);
    endtask : rd

    task automatic wr(input logic sel, input logic [7:0] d);
        host.cyc({1'b0, sel, 2'b10}, d, q, oe);
    endtask : wr

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out

    initial begin
        repeat (5000) @(posedge clock);
        fails++;
        close_out();
    end

    initial begin
        {multi_char, tx_last_char, tx_busy, rx_first, rx_parity_bad} = 5'h00;
        {tx_shift_load, tx_char_done, rx_char_done, rx_seq_bad} = 4'h0;
        rx_char = 8'h00;
        fails = 0;
        checks_done = 0;
        wr_pulses = 0;
        rst_n = 1'b0;
        repeat (20) @(negedge clock);
        chk(status_flags, srts_pkg::STATUS_RESET);
        rst_n = 1'b1;
        host.cyc(4'b1101, 8'h00, q, oe);
        chk({7'h0, oe}, 8'h00);
        multi_char = 1'b1;
        rx_first = 1'b1;
        rx_char = 8'h3c;
        fire(4'b0010);
        chk(status_flags, 8'h47);
        rd(1'b1);
        chk({7'h0, oe}, 8'h01);
        chk(q, 8'h47);
        rd(1'b0);
        chk(q, 8'h3c);
        chk(status_flags, 8'h05);
        // Second character fills the emptied register; a third lands on it unread, with bad parity
        rx_first = 1'b0;
        fire(4'b0010);
        rx_parity_bad = 1'b1;
        rx_char = 8'hc3;
        fire(4'b0010);
        rx_parity_bad = 1'b0;
        chk(status_flags, 8'h3f);
        wr(1'b1, 8'ha5);
        chk(control_data, 8'ha5);
        chk(wr_pulses[7:0], 8'h01);
        chk(status_flags, 8'h07);
        rd(1'b0);
        chk(q, 8'hc3);
        fire(4'b0001);
        chk(status_flags, 8'h25);
        // Both strobes low must do nothing
        host.cyc(4'b0100, 8'h11, q, oe);
        chk(control_data, 8'ha5);
        chk({wr_pulses[6:0], oe}, 8'h02);
        wr(1'b1, 8'h00);
        wr(1'b0, 8'h5a);
        chk(tx_hold_data, 8'h5a);
        chk(status_flags, 8'h00);
        tx_busy = 1'b1;
        fire(4'b1000);
        chk({tx_hold_full, status_flags[6:0]}, 8'h01);
        fire(4'b0100);
        chk(status_flags, 8'ha1);
        tx_busy = 1'b0;
        repeat (2) @(negedge clock);
        chk(status_flags, 8'ha5);
        wr(1'b1, 8'h00);
        tx_busy = 1'b1;
        tx_last_char = 1'b1;
        fire(4'b0100);
        chk(status_flags, 8'h01);
        // Single-character words never underrun
        multi_char = 1'b0;
        tx_last_char = 1'b0;
        fire(4'b0100);
        chk(status_flags, 8'h01);
        // Mid-run reset brings back the idle flags and a released bus
        tx_busy = 1'b0;
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        chk(status_flags, srts_pkg::STATUS_RESET);
        chk(data_out, srts_pkg::DATA_OUT_RESET);
        chk({7'h0, data_oe}, 8'h00);
        rst_n = 1'b1;
        rd(1'b1);
        chk({7'h0, oe}, 8'h01);
        chk(q, srts_pkg::STATUS_RESET);
        close_out();
    end
endmodule : srts_status_port_tb_top
